// >>> core/lsr_cfg.svh
// Constants for the latched-address shared-bus byte memory.
// Assumes inclusion by bare name from the package, the byte store and the top module.
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH

`define LSR_ADDR_W    8
`define LSR_DATA_W    8
`define LSR_DEPTH     256
`define LSR_OE_RST    1'b0
`define LSR_BUS_RST   8'h00
`define LSR_MCLK_RST  1'b0
`define LSR_FLAG_RST  1'h0

`endif

// >>> core/lsr_pkg.sv
// Types for the latched-address shared-bus byte memory.
// Assumes lsr_cfg.svh is on the include path.
`include "lsr_cfg.svh"

package lsr_pkg;

  typedef logic [`LSR_ADDR_W-1:0] lsr_addr_t;
  typedef logic [`LSR_DATA_W-1:0] lsr_data_t;

  // Control pins, sampled on the system clock
  typedef struct packed {
    logic chip_access_enable_n;
    logic select_command;
    logic write_command;
    logic master_clk;
  } lsr_ctrl_t;

  // Bus mode decoded from the control pins
  typedef enum logic [2:0] {
    LSR_MODE_HOLD  = 3'b000,
    LSR_MODE_ADDR  = 3'b001,
    LSR_MODE_WRITE = 3'b010,
    LSR_MODE_READ  = 3'b011,
    LSR_MODE_CLASH = 3'b100
  } lsr_mode_t;

endpackage

// >>> core/lsr_byte_store.sv
// Byte storage array with one write port and one combinational read port.
// Assumes the caller sequences writes; contents have no reset.
`include "lsr_cfg.svh"

module lsr_byte_store
  import lsr_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      we_i,
  input  wire lsr_addr_t addr_i,
  input  wire lsr_data_t wdata_i,
  output lsr_data_t      rdata_o
);

  lsr_data_t mem [`LSR_DEPTH];

  // Store one byte, no reset on purpose
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  // Read the byte at the latched address
  assign rdata_o = mem[addr_i];

endmodule

// >>> core/lsr_shared_bus_ram.sv
// Latched-address byte memory on a shared bidirectional byte bus.
// Assumes all pins are synchronous to ref_clk_i; the master clock is a
// plain sampled input and its falling edge is found by comparison.
`include "lsr_cfg.svh"

// Contract
// - Array of 256 bytes, each 8 bits, picked by an 8-bit address.
// - Address, write data and read data share one three-state byte bus.
// - Access enable high: address held, bus released, other pins ignored.
// - Select high, write low: bus is address, captured at clock fall.
// - Select and write low with enable low: drive stored byte on bus.
// - Write high, select low: store bus byte at clock fall, bus off.
// - Drivers on when select or enable falls in read, off when rising.
module lsr_shared_bus_ram
  import lsr_pkg::*;
(
  input  wire logic      ref_clk_i,
  input  wire logic      srst_i,
  input  wire lsr_ctrl_t ctrl_i,
  input  wire lsr_data_t shared_byte_bus_i,
  output lsr_data_t      shared_byte_bus_o,
  output logic           shared_byte_bus_oe_o
);

  // Control state
  logic      mclk_prev;
  lsr_addr_t addr_latch;
  lsr_data_t bus_out;
  logic      bus_oe;

  // Decoded control
  wire logic      enable_n = ctrl_i.chip_access_enable_n;
  wire logic      sel_cmd  = ctrl_i.select_command;
  wire logic      wr_cmd   = ctrl_i.write_command;
  wire logic      mclk_fall;
  wire logic      load_addr;
  wire logic      store_byte;
  wire logic      next_bus_oe;
  lsr_mode_t      mode;
  lsr_data_t      rd_byte;

  // Mode decode from the control pins
  // enable high wins
  assign mode = enable_n           ? LSR_MODE_HOLD  :
                (sel_cmd & wr_cmd) ? LSR_MODE_CLASH :
                sel_cmd            ? LSR_MODE_ADDR  :
                wr_cmd             ? LSR_MODE_WRITE :
                                     LSR_MODE_READ;

  // Falling edge of the sampled master clock
  assign mclk_fall = mclk_prev & ~ctrl_i.master_clk;

  assign load_addr  = mclk_fall & (mode == LSR_MODE_ADDR);
  // clash mode loads and stores nothing
  assign store_byte = mclk_fall & (mode == LSR_MODE_WRITE);

  assign next_bus_oe = (mode == LSR_MODE_READ);

  // Master clock history, reset so no false fall appears
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mclk_prev <= `LSR_MCLK_RST;
    end else begin
      mclk_prev <= ctrl_i.master_clk;
    end
  end

  // Address latch, deliberately without reset
  // no reset on the latch
  always_ff @(posedge ref_clk_i) begin
    if (load_addr) begin
      addr_latch <= shared_byte_bus_i;
    end
  end

  // Registered bus drive
  // three-state drive via enable
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      bus_oe  <= `LSR_OE_RST;
      bus_out <= `LSR_BUS_RST;
    end else begin
      bus_oe  <= next_bus_oe;
      bus_out <= rd_byte;
    end
  end

  lsr_byte_store u_store (
    .clk_i   (ref_clk_i),
    .we_i    (store_byte),
    .addr_i  (addr_latch),
    .wdata_i (shared_byte_bus_i),
    .rdata_o (rd_byte)
  );

  // Outputs straight from flops
  assign shared_byte_bus_o    = bus_out;
  assign shared_byte_bus_oe_o = bus_oe;

  // Check-side state, not part of the data path
  logic      addr_seen;
  logic      wr_seen;
  lsr_addr_t wr_addr_seen;
  lsr_data_t wr_data_seen;

  // Latch powers up unknown, so the hold checks wait for a first load
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      addr_seen <= `LSR_FLAG_RST;
    end else if (load_addr) begin
      addr_seen <= 1'h1;
    end
  end

  // Marks that the shadow below holds a real store
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_seen <= `LSR_FLAG_RST;
    end else if (store_byte) begin
      wr_seen <= 1'h1;
    end
  end

  // Shadow of the latest store, kept apart from the array so the
  // read-back check does not lean on the array's own read port
  always_ff @(posedge ref_clk_i) begin
    if (store_byte) begin
      wr_addr_seen <= addr_latch;
      wr_data_seen <= shared_byte_bus_i;
    end
  end

  // Checks on the bus behaviour; a never-written byte reads as unknown,
  // so the shadow read-back check only looks at bytes stored since power-up
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  chk_disabled_hold_off: assert property (
    enable_n |=> !shared_byte_bus_oe_o
                 && (!addr_seen || $stable(addr_latch)))
    else $error("bus driven or address moved while disabled");

  chk_addr_load_value: assert property (
    load_addr |=> (addr_latch == $past(shared_byte_bus_i))
                  && !shared_byte_bus_oe_o)
    else $error("address not captured at clock fall");

  chk_read_drive_on: assert property (
    (mode == LSR_MODE_READ) |=> shared_byte_bus_oe_o
      && (shared_byte_bus_o == $past(rd_byte)))
    else $error("stored byte not driven in read mode");

  chk_write_store_data: assert property (
    store_byte |=> (rd_byte == $past(shared_byte_bus_i))
                   && !shared_byte_bus_oe_o)
    else $error("written byte not stored or bus driven");

  chk_drive_only_read: assert property (
    shared_byte_bus_oe_o |-> $past(mode) == LSR_MODE_READ)
    else $error("bus driven outside read mode");

  chk_rise_drivers_off: assert property (
    ($rose(sel_cmd) || $rose(enable_n)) |=> !shared_byte_bus_oe_o)
    else $error("drivers not off after select or enable rise");

  chk_read_byte_path: assert property (
    (shared_byte_bus_oe_o && $stable(addr_latch)) |->
      shared_byte_bus_o == $past(rd_byte))
    else $error("driven byte differs from array output");

  chk_latch_only_load: assert property (
    (addr_latch != $past(addr_latch)) |-> $past(load_addr))
    else $error("address latch changed without a load");

  // Read-back against the shadow of the latest store
  chk_shadow_read_back: assert property (
    (shared_byte_bus_oe_o && wr_seen && (addr_latch == wr_addr_seen)) |->
      shared_byte_bus_o == wr_data_seen)
    else $error("driven byte differs from the last byte stored there");

  // Drivers stay off while the bus is an input
  chk_addr_mode_off: assert property (
    (mode == LSR_MODE_ADDR) |=> !shared_byte_bus_oe_o)
    else $error("bus driven while taking an address");

  chk_write_mode_off: assert property (
    (mode == LSR_MODE_WRITE) |=> !shared_byte_bus_oe_o)
    else $error("bus driven while taking write data");

  // A write leaves the latched address where it was
  chk_write_hold_addr: assert property (
    (store_byte && addr_seen) |=> $stable(addr_latch))
    else $error("address latch moved during a write");

  // Driver timing against the control edges
  chk_fall_drivers_on: assert property (
    (($fell(sel_cmd) || $fell(enable_n)) && (mode == LSR_MODE_READ))
      |=> shared_byte_bus_oe_o)
    else $error("drivers not on after select or enable fall");

  chk_write_rise_off: assert property (
    $rose(wr_cmd) |=> !shared_byte_bus_oe_o)
    else $error("drivers not off after write command rise");

endmodule

// >>> dv/lsr_host_model.sv
// Host model driving control pins and the shared byte bus.
// Assumes tasks are called 1 ns after a clock edge.
module lsr_host_model
  import lsr_pkg::*;
(
  input  wire logic      clk_i,
  input  wire lsr_data_t dev_bus_i,
  input  wire logic      dev_oe_i,
  output lsr_ctrl_t      ctrl_o,
  output lsr_data_t      wire_o
);
  timeunit 1ns;
  timeprecision 1ns;
  lsr_data_t drv;
  logic      drv_en;
  lsr_data_t last = 8'h00;
  // bus level; released bus shows inverse
  assign wire_o = dev_oe_i ? dev_bus_i : drv_en ? drv : ~last;
  // Remember the bus only while someone drives it
  always @(posedge clk_i) begin
    if (dev_oe_i || drv_en) begin
      last <= wire_o;
    end
  end
  initial begin
    ctrl_o = '{1'b1, 1'b1, 1'b0, 1'b0};
    drv = 8'h00;
    drv_en = 1'b0;
  end
  // drive with select, write or enable high
  task automatic xfer(input logic s, input logic w, input logic e,
                      input lsr_data_t d);
    ctrl_o <= '{e, s, w, 1'b1};
    drv <= d;
    drv_en <= 1'b1;
    @(posedge clk_i) #1;
    ctrl_o.master_clk <= 1'b0;
    @(posedge clk_i) #1;
    ctrl_o <= '{1'b1, 1'b1, 1'b0, 1'b0};
    drv_en <= 1'b0;
    // Idle edge so the next request starts in a fresh time step
    @(posedge clk_i) #1;
  endtask
  // Read with all commands low
  task automatic rd(output logic on, output lsr_data_t d,
                    output logic off);
    ctrl_o <= '0;
    @(posedge clk_i) #1;
    on = dev_oe_i;
    d = wire_o;
    ctrl_o.select_command <= 1'b1;
    @(posedge clk_i) #1;
    off = dev_oe_i;
    ctrl_o.chip_access_enable_n <= 1'b1;
    @(posedge clk_i) #1;
  endtask
endmodule

// >>> dv/latched_address_shared_bus_ram_test.sv
// Self-checking bench for the shared-bus byte memory.
// Assumes the host model drives all control pins.
module latched_address_shared_bus_ram_test;
  import lsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic      clk;
  logic      srst;
  lsr_ctrl_t ctrl;
  lsr_data_t bus_o;
  lsr_data_t bus_w;
  logic      oe;
  int        bad_count;
  int        n_tests;
  lsr_shared_bus_ram lsr_shared_bus_ram_i (
    .ref_clk_i(clk), .srst_i(srst), .ctrl_i(ctrl),
    .shared_byte_bus_i(bus_w), .shared_byte_bus_o(bus_o),
    .shared_byte_bus_oe_o(oe));
  lsr_host_model lsr_host_model_i (
    .clk_i(clk), .dev_bus_i(bus_o), .dev_oe_i(oe),
    .ctrl_o(ctrl), .wire_o(bus_w));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input lsr_data_t got, input lsr_data_t exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic rd_chk(input lsr_data_t exp);
    logic      on;
    logic      off;
    lsr_data_t d;
    lsr_host_model_i.rd(on, d, off);
    chk_flag(on, 1'b1);
    chk(d, exp);
    chk_flag(off, 1'b0);
  endtask
  // Boundary addresses 00 and ff plus 5a written, then read back
  task automatic t_write_read;
    lsr_data_t a[3] = '{8'h00, 8'hff, 8'h5a};
    foreach (a[i]) begin
      lsr_host_model_i.xfer(1'b1, 1'b0, 1'b0, a[i]);
      lsr_host_model_i.xfer(1'b0, 1'b1, 1'b0, a[i] ^ 8'hc3);
    end
    foreach (a[i]) begin
      lsr_host_model_i.xfer(1'b1, 1'b0, 1'b0, a[i]);
      rd_chk(a[i] ^ 8'hc3);
    end
  endtask
  // Load and write with enable high are ignored
  task automatic t_enable_high;
    lsr_host_model_i.xfer(1'b1, 1'b0, 1'b1, 8'h00);
    lsr_host_model_i.xfer(1'b0, 1'b1, 1'b1, 8'h11);
    rd_chk(8'h99);
  endtask
  initial begin
    bad_count = 0;
    n_tests = 0;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    t_write_read();
    t_enable_high();
    tally_and_finish();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100us;
    bad_count++;
    tally_and_finish();
  end
endmodule
